// ==== core/ddt_timing_ctrl.sv ====
// SDRAM timing configuration registers and command spacing logic.
//
// Notes on behaviour
// - Precharge period field, bits 26:24 of control 0, enforced as value plus one.
// - Activate to access delay, bits 22:20 of control 0, value plus one clocks.
// - External path latency field, bits 17:16, resets to 01; software writes 10.
// - Write data latency bits 13:12 give 0, 1, 2 clocks; 11 reserved.
// - Read latency bits 9:8 give 2, 2.5, 3 or 4 clocks.
// - Termination bits 5:4 apply to second generation memory only.
// - Memory termination latched at EMRS; on-chip termination follows live field.
// - Bit 3 selects 16-bit bus and wins over the 32-bit bit.
// - Bit 2 is read-only generation strap captured on the first clock after reset is released.
// - Bit 1 selects 32-bit bus; software must not leave it zero.
// - Control 1 bit 31 selects strobe mode, sent as EMRS bit 10.
// - Bits 30:28 of control 1 give read to non-write gap.
// - Bits 27:24 of control 1 give write to non-read gap.
// - Bits 22:20 of control 1 give read to write gap; zero means eight.
// - Reads to open pages may follow each other with no added gap.
// - Command spacing uses timing fields from both control registers.
// - Generation strap defaults to one, first generation.
`timescale 1ns/1ps
module ddt_timing_ctrl #(
	parameter int GAP_W = 4
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              gen_strap,
	input  wire logic [31:0]       avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              cmd_valid,
	input  wire ddt_pkg::ddt_cmd_s cmd_req,
	output logic                   cmd_ready,
	output logic                   cmd_out_valid,
	output ddt_pkg::ddt_cmd_s      cmd_out,
	output ddt_pkg::ddt_cfg_s      cfg,
	output logic [31:0]            ctrl0_word,
	output logic [31:0]            ctrl1_word,
	output logic [1:0]             mem_term_code,
	output logic                   emrs_strobe_bit,
	output ddt_pkg::ddt_term_e     onchip_term
);
	import ddt_pkg::*;

	// Refuses gap counters too narrow for the fifteen-clock write to non-read gap.
	// The check runs at elaboration so a bad width never builds.
	if (GAP_W < 4) begin : g_gap_w_check
		$error("ddt_timing_ctrl needs gap counters of at least four bits");
	end

	localparam int NT   = 5;
	localparam int T_PRE = 0;
	localparam int T_ACT = 1;
	localparam int T_RTO = 2;
	localparam int T_RTW = 3;
	localparam int T_WTO = 4;

	// ==========================================================
	// Declarations
	logic [31:0]  ctrl0_ff;
	logic [31:0]  nxt_ctrl0;
	logic [31:0]  ctrl1_ff;
	logic [31:0]  nxt_ctrl1;
	logic         gen_ff;
	logic         nxt_gen;
	logic         strap_done_ff;
	logic         nxt_strap_done;
	logic         ack_ff;
	logic         nxt_ack;
	logic [31:0]  rdata_ff;
	logic [31:0]  nxt_rdata;
	logic         out_valid_ff;
	logic         nxt_out_valid;
	ddt_cmd_s     out_cmd_ff;
	ddt_cmd_s     nxt_out_cmd;
	ddt_cfg_s     cfg_ff;
	ddt_cfg_s     nxt_cfg;
	logic [31:0]  be_mask;
	logic [31:0]  ctrl0_view;
	logic         cmd_fire;
	logic         is_read;
	logic         is_write;
	logic [2:0]   rto_f;
	logic [3:0]   wto_f;
	logic [2:0]   rtw_f;
	logic [NT-1:0] t_start;
	logic [NT-1:0] t_idle;
	logic [GAP_W-1:0] t_load [NT];

	// ==========================================================
	// Register bus
	// Byte enables widen to a bit mask for the write merge.
	assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// Control 0 as read: stored bits plus the strap-driven generation bit.
	always_comb begin
		ctrl0_view = ctrl0_ff;
		ctrl0_view[DDT_GEN_BIT] = gen_ff;
	end

	// Every access stalls one cycle, then is acknowledged for one cycle.
	always_comb begin
		nxt_ack   = (avs_read | avs_write) & ~ack_ff;
		nxt_rdata = rdata_ff;
		nxt_ctrl0 = ctrl0_ff;
		nxt_ctrl1 = ctrl1_ff;
		if (nxt_ack && avs_read) begin
			if (avs_address == DDT_CTRL0_ADDR) begin
				nxt_rdata = ctrl0_view;
			end else if (avs_address == DDT_CTRL1_ADDR) begin
				nxt_rdata = ctrl1_ff;
			end else begin
				nxt_rdata = 32'h0000_0000;
			end
		end
		if (ack_ff && avs_write) begin
			// Only writable bits change; reserved bits stay zero.
			if (avs_address == DDT_CTRL0_ADDR) begin
				nxt_ctrl0 = (ctrl0_ff & ~(be_mask & DDT_CTRL0_WMASK)) |
					(avs_writedata & be_mask & DDT_CTRL0_WMASK);
			end else if (avs_address == DDT_CTRL1_ADDR) begin
				nxt_ctrl1 = (ctrl1_ff & ~(be_mask & DDT_CTRL1_WMASK)) |
					(avs_writedata & be_mask & DDT_CTRL1_WMASK);
			end
		end
	end

	// Registers the bus state and both control registers.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			ctrl0_ff <= DDT_CTRL0_RST;
			ctrl1_ff <= DDT_CTRL1_RST;
		end else begin
			ack_ff   <= nxt_ack;
			rdata_ff <= nxt_rdata;
			ctrl0_ff <= nxt_ctrl0;
			ctrl1_ff <= nxt_ctrl1;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign avs_readdata    = rdata_ff;
	assign ctrl0_word      = ctrl0_view;
	assign ctrl1_word      = ctrl1_ff;

	// ==========================================================
	// Generation strap
	// The strap is caught on the first edge after reset is released.
	always_comb begin
		nxt_gen        = gen_ff;
		nxt_strap_done = 1'b1;
		if (!strap_done_ff) begin
			nxt_gen = gen_strap;
		end
	end

	// Registers the strap; it reads as first generation until caught.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			gen_ff        <= DDT_GEN_RST;
			strap_done_ff <= 1'b0;
		end else begin
			gen_ff        <= nxt_gen;
			strap_done_ff <= nxt_strap_done;
		end
	end

	// ==========================================================
	// Decoded configuration
	// Latencies and bus width for the data path, taken from control 0.
	always_comb begin
		nxt_cfg = '0;
		nxt_cfg.ext_path_latency = ctrl0_ff[DDT_EDP_LSB +: 2];
		nxt_cfg.write_data_latency = ctrl0_ff[DDT_WDL_LSB +: 2];
		if (ctrl0_ff[DDT_WDL_LSB +: 2] == 2'b11) begin
			nxt_cfg.write_data_latency = DDT_WDL_MAX;
		end
		// Read latency is given in half clocks so 2.5 stays exact.
		case (ctrl0_ff[DDT_RL_LSB +: 2])
			2'b00: nxt_cfg.read_latency_half = 4'h4;
			2'b01: nxt_cfg.read_latency_half = 4'h5;
			2'b10: nxt_cfg.read_latency_half = 4'h6;
			default: nxt_cfg.read_latency_half = 4'h8;
		endcase
		nxt_cfg.bus16 = ctrl0_ff[DDT_BUS16_BIT];
		nxt_cfg.bus32 = ~ctrl0_ff[DDT_BUS16_BIT] & ctrl0_ff[DDT_BUS32_BIT];
		nxt_cfg.gen1  = gen_ff;
	end

	// Registers the decoded configuration.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_ff <= '0;
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end

	assign cfg = cfg_ff;

	// ==========================================================
	// Command spacing
	assign rto_f = ctrl1_ff[DDT_RTO_LSB +: 3];
	assign wto_f = ctrl1_ff[DDT_WTO_LSB +: 4];
	assign rtw_f = ctrl1_ff[DDT_RTW_LSB +: 3];

	assign is_read  = (cmd_req.kind == DDT_CMD_READ);
	assign is_write = (cmd_req.kind == DDT_CMD_WRITE);

	// Each load is the gap minus one, since the timer adds the issue cycle.
	always_comb begin
		t_load[T_PRE] = GAP_W'(ctrl0_ff[DDT_PRE_LSB +: 3]);
		t_load[T_ACT] = GAP_W'(ctrl0_ff[DDT_ACT_LSB +: 3]);
		t_load[T_RTO] = (rto_f == 3'h0) ? '0 : GAP_W'(rto_f - 3'h1);
		t_load[T_RTW] = (rtw_f == 3'h0) ? GAP_W'(DDT_RTW_ZERO_LOAD) :
			GAP_W'(rtw_f - 3'h1);
		t_load[T_WTO] = (wto_f == 4'h0) ? '0 : GAP_W'(wto_f - 4'h1);
	end

	// A command waits until every timer that governs its kind has run down.
	always_comb begin
		cmd_ready = 1'b1;
		case (cmd_req.kind)
			DDT_CMD_ACT: cmd_ready = t_idle[T_PRE];
			DDT_CMD_READ: cmd_ready = t_idle[T_ACT];
			DDT_CMD_WRITE: cmd_ready = t_idle[T_ACT] & t_idle[T_RTW];
			default: cmd_ready = 1'b1;
		endcase
		// Reads to an open page skip the read turnaround gap.
		if (!is_write && !(is_read && cmd_req.page_open)) begin
			cmd_ready = cmd_ready & t_idle[T_RTO];
		end
		if (!is_read) begin
			cmd_ready = cmd_ready & t_idle[T_WTO];
		end
	end

	assign cmd_fire = cmd_valid & cmd_ready;

	// Timer starts by issued command kind.
	always_comb begin
		t_start        = '0;
		t_start[T_PRE] = cmd_fire & (cmd_req.kind == DDT_CMD_PRE);
		t_start[T_ACT] = cmd_fire & (cmd_req.kind == DDT_CMD_ACT);
		t_start[T_RTO] = cmd_fire & is_read;
		t_start[T_RTW] = cmd_fire & is_read;
		t_start[T_WTO] = cmd_fire & is_write;
	end

	// One gap timer per spacing constraint.
	generate
		for (genvar i = 0; i < NT; i++) begin : g_gap
			ddt_gap_timer #(
				.W (GAP_W)
			) u_gap (
				.core_clk (core_clk),
				.rst      (rst),
				.start    (t_start[i]),
				.load     (t_load[i]),
				.idle     (t_idle[i])
			);
		end
	endgenerate

	// Issued command goes out registered for one cycle.
	always_comb begin
		nxt_out_valid = cmd_fire;
		nxt_out_cmd   = cmd_fire ? cmd_req : out_cmd_ff;
	end

	// Registers the issued command.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			out_valid_ff <= 1'b0;
			out_cmd_ff   <= '0;
		end else begin
			out_valid_ff <= nxt_out_valid;
			out_cmd_ff   <= nxt_out_cmd;
		end
	end

	assign cmd_out_valid = out_valid_ff;
	assign cmd_out       = out_cmd_ff;

	// ==========================================================
	// Termination and strobe
	ddt_term_emrs u_term (
		.core_clk        (core_clk),
		.rst             (rst),
		.emrs_issue      (cmd_fire & (cmd_req.kind == DDT_CMD_EMRS)),
		.term_field      (ctrl0_ff[DDT_TERM_LSB +: 2]),
		.strobe_single   (ctrl1_ff[DDT_STROBE_BIT]),
		.gen1            (gen_ff),
		.mem_term_code   (mem_term_code),
		.emrs_strobe_bit (emrs_strobe_bit),
		.onchip_term     (onchip_term)
	);

endmodule

// ==== core/ddt_pkg.sv ====
// Package of constants and carriers for the SDRAM timing configuration block.
package ddt_pkg;

	// ==========================================================
	// Register addresses, masks and reset values
	localparam logic [31:0] DDT_CTRL0_ADDR  = 32'hcc00_e504;
	localparam logic [31:0] DDT_CTRL1_ADDR  = 32'hcc00_e508;
	localparam logic [31:0] DDT_CTRL0_WMASK = 32'hf773_333b;
	localparam logic [31:0] DDT_CTRL1_WMASK = 32'hff71_ffff;
	localparam logic [31:0] DDT_CTRL0_RST   = 32'h0001_0000;
	localparam logic [31:0] DDT_CTRL1_RST   = 32'h0000_0000;
	localparam logic        DDT_GEN_RST     = 1'b1;

	// ==========================================================
	// Field positions in control register 0
	localparam int DDT_PRE_LSB   = 24;
	localparam int DDT_ACT_LSB   = 20;
	localparam int DDT_EDP_LSB   = 16;
	localparam int DDT_WDL_LSB   = 12;
	localparam int DDT_RL_LSB    = 8;
	localparam int DDT_TERM_LSB  = 4;
	localparam int DDT_BUS16_BIT = 3;
	localparam int DDT_GEN_BIT   = 2;
	localparam int DDT_BUS32_BIT = 1;

	// ==========================================================
	// Field positions in control register 1
	localparam int DDT_STROBE_BIT = 31;
	localparam int DDT_RTO_LSB    = 28;
	localparam int DDT_WTO_LSB    = 24;
	localparam int DDT_RTW_LSB    = 20;

	// ==========================================================
	// Timing constants
	localparam logic [3:0] DDT_RTW_ZERO_LOAD = 4'h7;
	localparam logic [1:0] DDT_WDL_MAX       = 2'h2;

	// ==========================================================
	// Command kinds seen by the spacing logic
	typedef enum logic [2:0] {
		DDT_CMD_ACT   = 3'b000,
		DDT_CMD_READ  = 3'b001,
		DDT_CMD_WRITE = 3'b010,
		DDT_CMD_PRE   = 3'b011,
		DDT_CMD_REF   = 3'b100,
		DDT_CMD_EMRS  = 3'b101
	} ddt_cmd_e;

	// On-chip termination settings.
	typedef enum logic [1:0] {
		DDT_TERM_OFF = 2'b00,
		DDT_TERM_75  = 2'b01,
		DDT_TERM_150 = 2'b10
	} ddt_term_e;

	// Command request from the command engine.
	typedef struct packed {
		ddt_cmd_e kind;
		logic     page_open;
	} ddt_cmd_s;

	// Decoded configuration for the data path.
	typedef struct packed {
		logic [1:0] ext_path_latency;
		logic [1:0] write_data_latency;
		logic [3:0] read_latency_half;
		logic       bus16;
		logic       bus32;
		logic       gen1;
	} ddt_cfg_s;

endpackage

// ==== core/ddt_gap_timer.sv ====
// Down counter that spaces one class of SDRAM commands.
`timescale 1ns/1ps
module ddt_gap_timer #(
	parameter int W = 4
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         start,
	input  wire logic [W-1:0] load,
	output logic              idle
);
	import ddt_pkg::*;

	// Refuses counters too narrow for the longest gap load.
	// The check runs at elaboration so a bad width never builds.
	if (W < 4) begin : g_width_check
		$error("ddt_gap_timer needs at least four bits");
	end

	logic [W-1:0] count_ff;
	logic [W-1:0] nxt_count;

	// ==========================================================
	// Count
	// A start loads gap minus one, so the next command may go load+1 cycles later.
	always_comb begin
		nxt_count = count_ff;
		if (start) begin
			nxt_count = load;
		end else if (count_ff != '0) begin
			nxt_count = count_ff - 1'b1;
		end
	end

	// Registers the count.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			count_ff <= '0;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// The timer permits its commands when it has run down.
	assign idle = (count_ff == '0);

endmodule

// ==== core/ddt_term_emrs.sv ====
// Termination and strobe settings for the extended mode register command.
`timescale 1ns/1ps
module ddt_term_emrs (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       emrs_issue,
	input  wire logic [1:0] term_field,
	input  wire logic       strobe_single,
	input  wire logic       gen1,
	output logic [1:0]      mem_term_code,
	output logic            emrs_strobe_bit,
	output ddt_pkg::ddt_term_e onchip_term
);
	import ddt_pkg::*;

	logic [1:0] mem_term_ff;
	logic [1:0] nxt_mem_term;
	logic       strobe_ff;
	logic       nxt_strobe;
	ddt_term_e  onchip_ff;
	ddt_term_e  nxt_onchip;

	// ==========================================================
	// Next values
	// Memory side is frozen at EMRS; on-chip side tracks the live field.
	always_comb begin
		nxt_mem_term = mem_term_ff;
		nxt_strobe   = strobe_ff;
		if (emrs_issue) begin
			nxt_mem_term = gen1 ? 2'h0 : term_field;
			nxt_strobe   = strobe_single;
		end
		nxt_onchip = DDT_TERM_OFF;
		if (!gen1) begin
			case (term_field)
				2'b01: nxt_onchip = DDT_TERM_150;
				2'b10: nxt_onchip = DDT_TERM_150;
				2'b11: nxt_onchip = DDT_TERM_75;
				default: nxt_onchip = DDT_TERM_OFF;
			endcase
		end
	end

	// Registers the termination and strobe state.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mem_term_ff <= 2'h0;
			strobe_ff   <= 1'b0;
			onchip_ff   <= DDT_TERM_OFF;
		end else begin
			mem_term_ff <= nxt_mem_term;
			strobe_ff   <= nxt_strobe;
			onchip_ff   <= nxt_onchip;
		end
	end

	assign mem_term_code   = mem_term_ff;
	assign emrs_strobe_bit = strobe_ff;
	assign onchip_term     = onchip_ff;

endmodule

// ==== tb/ddt_timing_ctrl_sva.sv ====
// Concurrent checks on the ports of the SDRAM timing configuration block.
`timescale 1ns/1ps
// ==========================================================
// Checker
module ddt_timing_ctrl_chk (
	input wire logic              core_clk,
	input wire logic              rst,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic              avs_waitrequest,
	input wire logic              cmd_valid,
	input wire ddt_pkg::ddt_cmd_s cmd_req,
	input wire logic              cmd_ready,
	input wire logic              cmd_out_valid,
	input wire ddt_pkg::ddt_cmd_s cmd_out,
	input wire ddt_pkg::ddt_cfg_s cfg,
	input wire logic [31:0]       ctrl0_word,
	input wire logic [31:0]       ctrl1_word,
	input wire logic [1:0]        mem_term_code,
	input wire logic              emrs_strobe_bit,
	input wire ddt_pkg::ddt_term_e onchip_term
);
	import ddt_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic       fire;
	logic [5:0] since_ff, nxt_since;
	ddt_cmd_e   last_ff, nxt_last;
	logic [31:0] w0_ff, w1_ff, nxt_w0, nxt_w1;
	logic [3:0] rtw_need;
	ddt_term_e  term_ff, nxt_term;
	assign fire = cmd_valid & cmd_ready;
	assign rtw_need = (w1_ff[22:20] == 3'h0) ? 4'h8 : {1'b0, w1_ff[22:20]};
	// Track the last issued command, its age and the fields loaded with it.
	always_comb begin
		nxt_since = (since_ff == 6'h3f) ? since_ff : since_ff + 6'h01;
		nxt_last = last_ff;
		nxt_w0 = w0_ff;
		nxt_w1 = w1_ff;
		if (fire) begin
			nxt_since = 6'h01;
			nxt_last = cmd_req.kind;
			nxt_w0 = ctrl0_word;
			nxt_w1 = ctrl1_word;
		end
		case (ctrl0_word[5:4])
			2'h0: nxt_term = DDT_TERM_OFF;
			2'h3: nxt_term = DDT_TERM_75;
			default: nxt_term = DDT_TERM_150;
		endcase
		if (ctrl0_word[2]) nxt_term = DDT_TERM_OFF;
	end
	// Register the tracking state.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			since_ff <= 6'h3f;
			last_ff <= DDT_CMD_REF;
			w0_ff <= 32'h0;
			w1_ff <= 32'h0;
			term_ff <= DDT_TERM_OFF;
		end else begin
			since_ff <= nxt_since;
			last_ff <= nxt_last;
			w0_ff <= nxt_w0;
			w1_ff <= nxt_w1;
			term_ff <= nxt_term;
		end
	end
	chk_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
		else $error("request answered without a wait cycle");
	chk_wait_once: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request waited more than one cycle");
	chk_cmd_issue: assert property (
		fire |=> cmd_out_valid && cmd_out == $past(cmd_req))
		else $error("issued command not presented next cycle");
	chk_pre_to_act: assert property (
		fire && cmd_req.kind == DDT_CMD_ACT && last_ff == DDT_CMD_PRE
		|-> since_ff > {3'h0, w0_ff[26:24]}) else $error("activate too soon after precharge");
	chk_act_to_access: assert property (
		fire && cmd_req.kind inside {DDT_CMD_READ, DDT_CMD_WRITE} && last_ff == DDT_CMD_ACT
		|-> since_ff > {3'h0, w0_ff[22:20]}) else $error("access too soon after activate");
	chk_read_to_write: assert property (
		fire && cmd_req.kind == DDT_CMD_WRITE && last_ff == DDT_CMD_READ
		|-> since_ff >= {2'h0, rtw_need}) else $error("write too soon after read");
	chk_read_to_other: assert property (
		fire && last_ff == DDT_CMD_READ && cmd_req.kind != DDT_CMD_WRITE
		&& !(cmd_req.kind == DDT_CMD_READ && cmd_req.page_open)
		|-> since_ff >= {3'h0, w1_ff[30:28]}) else $error("command too soon after read");
	chk_write_to_other: assert property (
		fire && last_ff == DDT_CMD_WRITE && cmd_req.kind != DDT_CMD_READ
		|-> since_ff >= {2'h0, w1_ff[27:24]}) else $error("command too soon after write");
	chk_open_reads: assert property (
		cmd_valid && cmd_req.kind == DDT_CMD_READ && cmd_req.page_open
		&& last_ff == DDT_CMD_READ && since_ff == 6'h01 |-> cmd_ready)
		else $error("open page read held back");
	chk_reserved_zero: assert property (
		(ctrl0_word & 32'h088c_ccc0) == 32'h0 && (ctrl1_word & 32'h008e_0000) == 32'h0)
		else $error("reserved bit set");
	chk_bus_width: assert property (
		1'b1 |=> cfg.bus16 == $past(ctrl0_word[3])
		&& cfg.bus32 == $past(!ctrl0_word[3] && ctrl0_word[1])) else $error("bus width wrong");
	chk_onchip_term: assert property (onchip_term == term_ff)
		else $error("on-chip termination wrong");
	chk_emrs_latch: assert property (
		fire && cmd_req.kind == DDT_CMD_EMRS |=> emrs_strobe_bit == $past(ctrl1_word[31])
		&& mem_term_code == ($past(ctrl0_word[2]) ? 2'h0 : $past(ctrl0_word[5:4])))
		else $error("extended mode values wrong");
endmodule

bind ddt_timing_ctrl ddt_timing_ctrl_chk ddt_timing_ctrl_chk_inst (.core_clk, .rst, .avs_read,
	.avs_write, .avs_waitrequest, .cmd_valid, .cmd_req, .cmd_ready, .cmd_out_valid, .cmd_out, .cfg,
	.ctrl0_word, .ctrl1_word, .mem_term_code, .emrs_strobe_bit, .onchip_term);

// ==== tb/ddt_sdram_model.sv ====
// Behavioural model of the SDRAM devices fed by the command port.
`timescale 1ns/1ps
module ddt_sdram_model (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              cmd_out_valid,
	input  wire ddt_pkg::ddt_cmd_s cmd_out,
	input  wire logic [1:0]        mem_term_code,
	input  wire logic              emrs_strobe_bit,
	output logic [1:0]             emrs_term,
	output logic                   emrs_strobe,
	output logic [7:0]             cmd_count
);
	import ddt_pkg::*;
	// Count commands and take the extended mode settings when one arrives.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			emrs_term <= 2'h0;
			emrs_strobe <= 1'b0;
			cmd_count <= 8'h00;
		end else if (cmd_out_valid) begin
			cmd_count <= cmd_count + 8'h01;
			if (cmd_out.kind == DDT_CMD_EMRS) begin
				emrs_term <= mem_term_code;
				emrs_strobe <= emrs_strobe_bit;
			end
		end
	end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking testbench for the SDRAM timing configuration block.
`timescale 1ns/1ps
module tb_top;
	import ddt_pkg::*;
	logic        core_clk = 0, rst = 1, gen_strap = 1, avs_read = 0, avs_write = 0;
	logic        cmd_valid = 0, avs_waitrequest, cmd_ready, cmd_out_valid;
	logic        emrs_strobe_bit, m_strobe;
	logic [31:0] avs_address = 0, avs_writedata = 0, avs_readdata, ctrl0_word, ctrl1_word, rd;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [1:0]  mem_term_code, m_term;
	logic [7:0]  m_count;
	ddt_cmd_s    cmd_req = '0, cmd_out;
	ddt_cfg_s    cfg;
	ddt_term_e   onchip_term;
	int          miscompares = 0, checked = 0, cycles = 0;
	localparam logic [31:0] A0 = DDT_CTRL0_ADDR;
	localparam logic [31:0] A1 = DDT_CTRL1_ADDR;
	ddt_timing_ctrl ddt_timing_ctrl_inst (.core_clk, .rst, .gen_strap, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cmd_valid,
		.cmd_req, .cmd_ready, .cmd_out_valid, .cmd_out, .cfg, .ctrl0_word, .ctrl1_word,
		.mem_term_code, .emrs_strobe_bit, .onchip_term);
	ddt_sdram_model ddt_sdram_model_inst (.core_clk, .rst, .cmd_out_valid, .cmd_out,
		.mem_term_code, .emrs_strobe_bit, .emrs_term(m_term), .emrs_strobe(m_strobe),
		.cmd_count(m_count));
	// Clock at 25 MHz.
	initial forever #20 core_clk = ~core_clk;
	// Cut a hang short.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			test_done;
		end
	end
	task test_done;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	// One bus access, held until waitrequest is seen low at a falling edge.
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(negedge core_clk);
		while (avs_waitrequest) @(negedge core_clk);
		@(posedge core_clk);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task rdchk(input logic [31:0] a, input logic [31:0] e, input string m);
		bus(1'b0, a, 32'h0);
		chk(rd, e, m);
	endtask
	task do_reset(input logic s);
		rst <= 1'b1;
		gen_strap <= s;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
	endtask
	// Hold a command until it issues; n is the expected count of refused cycles.
	task cmd(input ddt_cmd_e k, input logic po, input int n);
		int w;
		w = 0;
		cmd_valid <= 1'b1;
		cmd_req <= '{kind: k, page_open: po};
		@(negedge core_clk);
		while (!cmd_ready && w < 20) begin
			w++;
			@(negedge core_clk);
		end
		@(posedge core_clk);
		chk(w, n, "command spacing");
	endtask
	// Main sequence.
	initial begin
		do_reset(1'b1);
		rdchk(A0, 32'h0001_0004, "ctrl0 reset first gen");
		rdchk(A1, 32'h0, "ctrl1 reset");
		bus(1'b1, A0, 32'h0000_0012);
		repeat (2) @(negedge core_clk);
		chk(onchip_term, DDT_TERM_OFF, "termination with first gen");
		bus(1'b1, 32'hcc00_e50c, 32'hffff_ffff);
		rdchk(32'hcc00_e50c, 32'h0, "unmapped read");
		do_reset(1'b0);
		rdchk(A0, 32'h0001_0000, "ctrl0 reset second gen");
		bus(1'b1, A0, 32'h0abe_ded6);
		rdchk(A0, 32'h0232_1212, "ctrl0 fields");
		chk(cfg, {2'b10, 2'b01, 4'h6, 1'b0, 1'b1, 1'b0}, "decoded config");
		bus(1'b1, A1, 32'hd680_0000);
		rdchk(A1, 32'hd600_0000, "ctrl1 fields");
		cmd(DDT_CMD_PRE, 1'b0, 0);
		cmd(DDT_CMD_ACT, 1'b0, 2);
		cmd(DDT_CMD_READ, 1'b0, 3);
		cmd(DDT_CMD_READ, 1'b1, 0);
		cmd(DDT_CMD_WRITE, 1'b0, 7);
		cmd(DDT_CMD_PRE, 1'b0, 5);
		cmd(DDT_CMD_ACT, 1'b0, 2);
		cmd(DDT_CMD_WRITE, 1'b0, 3);
		cmd(DDT_CMD_EMRS, 1'b0, 5);
		cmd_valid <= 1'b0;
		repeat (2) @(negedge core_clk);
		chk(m_term, 2'b01, "memory termination at extended mode");
		chk(m_strobe, 1'b1, "single ended strobe");
		chk(m_count, 8'h09, "command count");
		bus(1'b1, A0, 32'h0232_1232);
		repeat (2) @(negedge core_clk);
		chk(onchip_term, DDT_TERM_75, "on-chip follows field");
		chk(mem_term_code, 2'b01, "memory termination kept");
		bus(1'b1, A0, 32'h0232_121a);
		repeat (2) @(negedge core_clk);
		chk({cfg.bus16, cfg.bus32}, 2'b10, "narrow bus wins");
		test_done;
	end
endmodule
